// ===== shared/udqs_pkg.sv
// Constants, types and register map of the USB DMA queue manager and credit scheduler.
// Function
// - Queues 24 and 25 take transmit completions and raise a transmit interrupt.
// - Queues 26 and 27 take receive completions and raise a receive interrupt.
// - Queues 28 to 63 are general, for completion or free descriptors.
// - Completions returned to general queues raise no interrupt, only append.
// - A finished teardown pushes its descriptor onto the channel completion queue.
// - A diversion write moves a whole source queue onto the destination head or tail.
// - Up to sixteen descriptor regions, each with one programmable descriptor size.
// - Descriptors are known inside by a 16-bit index, at most 64K of them.
// - Linking RAM holds the next index per descriptor; regions state first index.
// - Descriptor address comes from index, region base, region first index and region size.
// - A received zero-length packet passes count 0 with the zero-byte flag set.
// - A transmit descriptor with the zero-byte flag sends a zero-length packet.
// - The scheduler table holds 256 entries of channel and direction.
// - The table is write-only; reads of it return zero.
// - The final-slot field of control register one marks the last used entry.
// - The enable bit starts the scheduler; table writes are taken while enabled.
// - On enable the scheduler starts at table index 0.
// - An entry is eligible when its channel is on and its FIFO can work.
// - An eligible entry offers a credit and holds until the DMA accepts it.
// - The index advances after acceptance, or at once for an ineligible entry.
// - Stepping past the final slot wraps the index to 0.
// - A write to a queue push register appends the descriptor at its tail.
// - A read of a queue pop register returns and removes the head descriptor.
package udqs_pkg;
    localparam int NUM_QUEUES = 64;
    localparam int NUM_REGIONS = 16;
    localparam int TAB_DEPTH = 256;
    localparam int NUM_CHAN = 4;
    localparam int LINK_DEPTH = 65536;
    localparam logic [5:0] Q_TXCMP0 = 6'h18;
    localparam logic [5:0] Q_TXCMP1 = 6'h19;
    localparam logic [5:0] Q_RXCMP0 = 6'h1A;
    localparam logic [5:0] Q_RXCMP1 = 6'h1B;
    // Register byte offsets; address bits 9..8 select the bank.
    localparam logic [7:0] OFS_DIVERT = 8'h00;
    localparam logic [7:0] OFS_SCHED_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_TAB_WR = 8'h0C;
    localparam logic [1:0] BANK_CTRL = 2'h0;
    localparam logic [1:0] BANK_REGION = 2'h1;
    localparam logic [1:0] BANK_QPOP = 2'h2;
    localparam logic [1:0] BANK_QCNT = 2'h3;
    localparam logic [1:0] RG_BASE = 2'h0;
    localparam logic [1:0] RG_CTRL = 2'h1;
    localparam logic [1:0] RG_COUNT = 2'h2;
    // Field positions.
    localparam int DIV_DST_LSB = 16;
    localparam int DIV_TAIL_BIT = 31;
    localparam int SC_EN_BIT = 31;
    localparam int TW_CH_LSB = 8;
    localparam int TW_DIR_BIT = 15;
    localparam int RC_SIZE_LSB = 16;
    localparam int ST_PEND_BIT = 8;
    localparam int ZLP_BIT = 19;
    localparam logic [4:0] DESC_MIN_SHIFT = 5'h05;
    // Values after reset.
    localparam logic [7:0] SCHED_LAST_RST = 8'hFF;
    typedef enum logic [1:0] {SC_SCAN = 2'b01, SC_OFFER = 2'b10} udqs_sched_e;
    typedef struct packed {logic [15:0] head; logic [15:0] tail; logic [16:0] cnt;} udqs_queue_s;
    typedef struct packed {
        logic [31:0] base; logic [15:0] first; logic [3:0] size; logic [16:0] count;
    } udqs_region_s;
    typedef struct packed {logic valid; logic dir; logic [1:0] chan;} udqs_credit_s;
    typedef struct packed {logic valid; logic [5:0] queue; logic [31:0] ptr;} udqs_ret_s;
    typedef struct packed {logic valid; logic [15:0] len;} udqs_pkt_s;
    typedef struct packed {logic valid; logic [15:0] count; logic [31:0] info2;} udqs_blk_s;
    typedef struct packed {
        udqs_queue_s [NUM_QUEUES-1:0] q;
        udqs_region_s [NUM_REGIONS-1:0] rg;
        logic sen; logic [7:0] last; logic [7:0] sidx; udqs_sched_e sst; udqs_credit_s cred;
        logic waitreq; logic [31:0] rdata; logic ret_rdy; logic tx_irq; logic rx_irq;
        udqs_blk_s blk; udqs_pkt_s utx;
    } udqs_state_s;
endpackage

// ===== rtl/udqs_top.sv
// Queue manager, linking RAM, credit scheduler and zero-length handling of the USB DMA.
`timescale 1ns/1ps
`default_nettype none
module udqs_top (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Avalon-MM register slave, byte addressed.
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Descriptor returns and teardown completions from the DMA controller.
    input var udqs_pkg::udqs_ret_s ret,
    output logic ret_ready,
    // Completion events of the reserved queues.
    output logic tx_cmp_irq,
    output logic rx_cmp_irq,
    // Channel state and credit handshake.
    input wire logic [3:0] chan_en,
    input wire logic [3:0] tx_fifo_full,
    input wire logic [3:0] rx_fifo_empty,
    input wire logic cred_ready,
    output var udqs_pkg::udqs_credit_s cred,
    // Transfer side: USB receive to core, core transmit to USB.
    input var udqs_pkg::udqs_pkt_s usb_rx,
    output var udqs_pkg::udqs_blk_s core_blk,
    input var udqs_pkg::udqs_blk_s core_tx,
    output var udqs_pkg::udqs_pkt_s usb_tx
);
    import udqs_pkg::*;

    udqs_state_s st;
    udqs_state_s next_st;
    logic [15:0] link_ram [0:LINK_DEPTH-1];
    logic [2:0] tab_ram [0:TAB_DEPTH-1];
    logic lk_we;
    logic [15:0] lk_addr;
    logic [15:0] lk_data;
    logic tab_we;
    logic [7:0] tab_addr;
    logic [2:0] tab_data;
    logic ret_take;
    logic bus_go;
    logic wr_ok;
    logic push_en;
    logic [5:0] push_q;
    logic [15:0] push_idx;
    logic [16:0] ret_hit;
    logic [16:0] bus_hit;
    logic [32:0] pop_addr;
    logic [2:0] ent;
    logic elig;
    logic [7:0] nidx;
    logic [5:0] dsrc;
    logic [5:0] ddst;
    logic [16:0] push_cnt_now;
    logic tx_ret_hit;
    logic div_go;
    logic [16:0] div_sum;
    logic [5:0] pop_q;
    logic [16:0] pop_cnt_now;

    // Index of a descriptor address: hit flag and 16-bit index.
    function automatic logic [16:0] addr_to_idx(input udqs_region_s [NUM_REGIONS-1:0] rg,
                                                input logic [31:0] a);
        logic [16:0] res;
        logic [31:0] off;
        logic [31:0] slot;
        res = 17'h00000;
        for (int r = 0; r < NUM_REGIONS; r++) begin
            off = a - rg[r].base;
            slot = off >> (DESC_MIN_SHIFT + 5'(rg[r].size));
            if (a >= rg[r].base && slot < 32'(rg[r].count)) begin
                res = {1'b1, rg[r].first + slot[15:0]};
            end
        end
        return res;
    endfunction

    // Address of a descriptor index: hit flag and 32-bit address.
    function automatic logic [32:0] idx_to_addr(input udqs_region_s [NUM_REGIONS-1:0] rg,
                                                input logic [15:0] idx);
        logic [32:0] res;
        logic [16:0] d;
        res = 33'h000000000;
        for (int r = 0; r < NUM_REGIONS; r++) begin
            d = {1'b0, idx} - {1'b0, rg[r].first};
            if (idx >= rg[r].first && d < rg[r].count) begin
                res = {1'b1, rg[r].base + (32'(d) << (DESC_MIN_SHIFT + 5'(rg[r].size)))};
            end
        end
        return res;
    endfunction

    // Handshake qualifiers: a return takes priority unless the bus was refused last cycle.
    assign ret_take = ret.valid && st.ret_rdy;
    assign bus_go = (read || write) && st.waitreq && !ret_take;
    assign wr_ok = write && (byteenable == 4'hF);
    assign ret_hit = addr_to_idx(st.rg, ret.ptr);
    assign bus_hit = addr_to_idx(st.rg, writedata);
    assign dsrc = writedata[5:0];
    assign ddst = writedata[DIV_DST_LSB +: 6];
    assign ent = tab_ram[st.sidx];
    assign nidx = (st.sidx == st.last) ? 8'h00 : st.sidx + 8'h01;
    assign elig = chan_en[ent[1:0]] &&
                  (ent[2] ? !rx_fifo_empty[ent[1:0]] : !tx_fifo_full[ent[1:0]]);
    assign pop_addr = idx_to_addr(st.rg, st.q[address[7:2]].head);
    assign push_cnt_now = st.q[push_q].cnt;

    // Terms that the checks below watch: a transmit completion return, a diversion and a pop.
    assign tx_ret_hit = ret_take && ret_hit[16] &&
                        (ret.queue == Q_TXCMP0 || ret.queue == Q_TXCMP1);
    assign div_go = bus_go && address == {BANK_CTRL, OFS_DIVERT} && wr_ok && dsrc != ddst &&
                    st.q[dsrc].cnt != 17'h00000;
    assign div_sum = st.q[ddst].cnt + st.q[dsrc].cnt;
    assign pop_q = address[7:2];
    assign pop_cnt_now = st.q[pop_q].cnt;

    // Next-state logic of queues, regions, scheduler and transfer side.
    always_comb begin
        next_st = st;
        next_st.waitreq = !bus_go;
        next_st.ret_rdy = !((read || write) && st.waitreq && !bus_go);
        next_st.tx_irq = 1'b0;
        next_st.rx_irq = 1'b0;
        lk_we = 1'b0;
        lk_addr = 16'h0000;
        lk_data = 16'h0000;
        tab_we = 1'b0;
        tab_addr = 8'h00;
        tab_data = 3'h0;
        push_en = 1'b0;
        push_q = 6'h00;
        push_idx = 16'h0000;
        // Returned and teardown descriptors land on the queue the DMA names.
        if (ret_take && ret_hit[16]) begin
            push_en = 1'b1;
            push_q = ret.queue;
            push_idx = ret_hit[15:0];
            next_st.tx_irq = (ret.queue == Q_TXCMP0) || (ret.queue == Q_TXCMP1);
            next_st.rx_irq = (ret.queue == Q_RXCMP0) || (ret.queue == Q_RXCMP1);
        end
        // Register access, answered one cycle after it is taken.
        if (bus_go) begin
            next_st.rdata = 32'h00000000;
            unique case (address[9:8])
                BANK_CTRL: begin
                    if (address[7:0] == OFS_DIVERT && wr_ok && dsrc != ddst
                            && st.q[dsrc].cnt != 17'h00000) begin
                        if (st.q[ddst].cnt == 17'h00000) begin
                            next_st.q[ddst].head = st.q[dsrc].head;
                            next_st.q[ddst].tail = st.q[dsrc].tail;
                        end else if (writedata[DIV_TAIL_BIT]) begin
                            lk_we = 1'b1;
                            lk_addr = st.q[ddst].tail;
                            lk_data = st.q[dsrc].head;
                            next_st.q[ddst].tail = st.q[dsrc].tail;
                        end else begin
                            lk_we = 1'b1;
                            lk_addr = st.q[dsrc].tail;
                            lk_data = st.q[ddst].head;
                            next_st.q[ddst].head = st.q[dsrc].head;
                        end
                        next_st.q[ddst].cnt = st.q[ddst].cnt + st.q[dsrc].cnt;
                        next_st.q[dsrc].cnt = 17'h00000;
                    end
                    if (address[7:0] == OFS_SCHED_CTRL1) begin
                        if (wr_ok) begin
                            next_st.last = writedata[7:0];
                            next_st.sen = writedata[SC_EN_BIT];
                        end
                        next_st.rdata = {st.sen, 23'h000000, st.last};
                    end
                    if (address[7:0] == OFS_STATUS) begin
                        next_st.rdata = {23'h000000, st.cred.valid, st.sidx};
                    end
                    if (address[7:0] == OFS_TAB_WR && wr_ok) begin
                        tab_we = 1'b1;
                        tab_addr = writedata[7:0];
                        tab_data = {writedata[TW_DIR_BIT], writedata[TW_CH_LSB +: 2]};
                    end
                end
                BANK_REGION: begin
                    unique case (address[3:2])
                        RG_BASE: begin
                            if (wr_ok) next_st.rg[address[7:4]].base = writedata;
                            next_st.rdata = st.rg[address[7:4]].base;
                        end
                        RG_CTRL: begin
                            if (wr_ok) begin
                                next_st.rg[address[7:4]].first = writedata[15:0];
                                next_st.rg[address[7:4]].size = writedata[RC_SIZE_LSB +: 4];
                            end
                            next_st.rdata = {12'h000, st.rg[address[7:4]].size,
                                             st.rg[address[7:4]].first};
                        end
                        RG_COUNT: begin
                            if (wr_ok) next_st.rg[address[7:4]].count = writedata[16:0];
                            next_st.rdata = {15'h0000, st.rg[address[7:4]].count};
                        end
                        default: begin
                            next_st.rdata = 32'h00000000;
                        end
                    endcase
                end
                BANK_QPOP: begin
                    if (wr_ok && bus_hit[16]) begin
                        push_en = 1'b1;
                        push_q = address[7:2];
                        push_idx = bus_hit[15:0];
                    end
                    if (read && st.q[address[7:2]].cnt != 17'h00000) begin
                        next_st.rdata = pop_addr[31:0];
                        next_st.q[address[7:2]].head = link_ram[st.q[address[7:2]].head];
                        next_st.q[address[7:2]].cnt = st.q[address[7:2]].cnt - 17'h00001;
                    end
                end
                BANK_QCNT: begin
                    next_st.rdata = {15'h0000, st.q[address[7:2]].cnt};
                end
            endcase
        end
        // Append at the tail; a non-empty queue links its old tail to the new entry.
        if (push_en) begin
            if (st.q[push_q].cnt == 17'h00000) begin
                next_st.q[push_q].head = push_idx;
            end else begin
                lk_we = 1'b1;
                lk_addr = st.q[push_q].tail;
                lk_data = push_idx;
            end
            next_st.q[push_q].tail = push_idx;
            next_st.q[push_q].cnt = st.q[push_q].cnt + 17'h00001;
        end
        // Credit scheduler walking the table.
        if (!st.sen) begin
            next_st.sidx = 8'h00;
            next_st.cred.valid = 1'b0;
            next_st.sst = SC_SCAN;
        end else begin
            unique case (st.sst)
                SC_SCAN: begin
                    if (elig) begin
                        next_st.cred = {1'b1, ent[2], ent[1:0]};
                        next_st.sst = SC_OFFER;
                    end else begin
                        next_st.sidx = nidx;
                    end
                end
                SC_OFFER: begin
                    if (cred_ready) begin
                        next_st.cred.valid = 1'b0;
                        next_st.sidx = nidx;
                        next_st.sst = SC_SCAN;
                    end
                end
            endcase
        end
        // Zero-length packets in both directions.
        next_st.blk.valid = usb_rx.valid;
        next_st.blk.count = usb_rx.len;
        next_st.blk.info2 = 32'h00000000;
        next_st.blk.info2[ZLP_BIT] = (usb_rx.len == 16'h0000);
        next_st.utx.valid = core_tx.valid;
        next_st.utx.len = core_tx.info2[ZLP_BIT] ? 16'h0000 : core_tx.count;
    end

    // State register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.waitreq <= 1'b1;
            st.ret_rdy <= 1'b1;
            st.last <= SCHED_LAST_RST;
            st.sst <= SC_SCAN;
        end else begin
            st <= next_st;
        end
    end

    // Linking RAM and scheduler table write ports; contents need no reset.
    always_ff @(posedge clk) begin
        if (lk_we) begin
            link_ram[lk_addr] <= lk_data;
        end
        if (tab_we) begin
            tab_ram[tab_addr] <= tab_data;
        end
    end

    // Outputs straight from state flops.
    assign readdata = st.rdata;
    assign waitrequest = st.waitreq;
    assign ret_ready = st.ret_rdy;
    assign tx_cmp_irq = st.tx_irq;
    assign rx_cmp_irq = st.rx_irq;
    assign cred = st.cred;
    assign core_blk = st.blk;
    assign usb_tx = st.utx;

    // Checks on the guarded behaviour.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_TX_IRQ: assert property (
        tx_ret_hit |=> tx_cmp_irq && !rx_cmp_irq ##1 tx_cmp_irq == $past(tx_ret_hit))
        else $error("Transmit completion did not pulse its interrupt.");
    AST_RX_IRQ: assert property (
        ret_take && ret_hit[16] && (ret.queue == Q_RXCMP0 || ret.queue == Q_RXCMP1)
        |=> rx_cmp_irq && !tx_cmp_irq)
        else $error("Receive completion did not raise its interrupt.");
    AST_GEN_NOIRQ: assert property (
        ret_take && ret.queue >= 6'h1C |=> !tx_cmp_irq && !rx_cmp_irq)
        else $error("General queue completion raised an interrupt.");
    AST_PUSH_CNT: assert property (
        push_en |=> st.q[$past(push_q)].cnt == $past(push_cnt_now) + 17'h00001)
        else $error("Push did not grow the queue by one.");
    AST_POP_EMPTY: assert property (
        bus_go && read && address[9:8] == BANK_QPOP && st.q[address[7:2]].cnt == 17'h00000
        |=> !waitrequest && readdata == 32'h00000000)
        else $error("Pop of an empty queue did not return zero.");
    AST_TAB_READ: assert property (
        bus_go && read && address == {BANK_CTRL, OFS_TAB_WR} |=> readdata == 32'h00000000)
        else $error("Scheduler table read returned data.");
    AST_IDLE_IDX: assert property (
        !st.sen |=> st.sidx == 8'h00 && !cred.valid)
        else $error("Disabled scheduler moved or offered a credit.");
    AST_CRED_HOLD: assert property (
        cred.valid && !cred_ready && st.sen |=> cred.valid && $stable(cred.chan)
        && $stable(cred.dir) && $stable(st.sidx))
        else $error("Credit dropped before acceptance.");
    AST_SKIP: assert property (
        st.sen && st.sst == SC_SCAN && !elig && st.sidx != st.last
        |=> st.sidx == $past(st.sidx) + 8'h01 && !cred.valid)
        else $error("Ineligible entry did not advance the index.");
    AST_WRAP: assert property (
        st.sen && st.sst == SC_OFFER && cred_ready && st.sidx == st.last |=> st.sidx == 8'h00)
        else $error("Index did not wrap after the final slot.");
    AST_ZLP_RX: assert property (
        usb_rx.valid && usb_rx.len == 16'h0000
        |=> core_blk.valid && core_blk.count == 16'h0000 && core_blk.info2[ZLP_BIT])
        else $error("Zero-length receive lost its flag.");
    AST_ZLP_TX: assert property (
        core_tx.valid && core_tx.info2[ZLP_BIT] |=> usb_tx.valid && usb_tx.len == 16'h0000)
        else $error("Zero-byte transmit sent a nonzero length.");
    AST_DIVERT: assert property (
        div_go |=> st.q[$past(dsrc)].cnt == 17'h00000
        && st.q[$past(ddst)].cnt == $past(div_sum))
        else $error("Diversion did not move the whole source queue.");
    AST_POP_DEC: assert property (
        bus_go && read && address[9:8] == BANK_QPOP && pop_cnt_now != 17'h00000
        |=> st.q[$past(pop_q)].cnt == $past(pop_cnt_now) - 17'h00001)
        else $error("Pop did not shrink the queue by one.");
    AST_BUS_ONE: assert property (
        !waitrequest |=> waitrequest)
        else $error("Bus answer stood longer than one cycle.");
    AST_CRED_DROP: assert property (
        st.sen && cred.valid && cred_ready
        |=> !cred.valid && st.sidx == $past(nidx))
        else $error("Accepted credit did not step the index.");
    AST_RET_DROP: assert property (
        ret_take && !ret_hit[16] |=> !tx_cmp_irq && !rx_cmp_irq)
        else $error("Unmatched return raised an interrupt.");

    COV_CREDIT: cover property (cred.valid && !cred_ready ##1 cred.valid && cred_ready);
    COV_WRAP: cover property (st.sen && st.sidx == st.last ##1 st.sidx == 8'h00);
    COV_TX_IRQ: cover property (tx_cmp_irq);
    COV_DIVERT: cover property (div_go);
    COV_POP: cover property (bus_go && read && address[9:8] == BANK_QPOP ##1 readdata != 0);
endmodule // udqs_top
`default_nettype wire

// ===== test/udqs_dma_model.sv
// DMA controller model that takes scheduler credits only while idle.
`timescale 1ns/1ps
`default_nettype none
module udqs_dma_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Credit handshake.
    input var udqs_pkg::udqs_credit_s cred,
    output logic cred_ready
);
    import udqs_pkg::*;
    logic [1:0] busy;
    // After each credit the model stays busy for a random spell, then returns to idle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 2'h0;
            cred_ready <= 1'b0;
        end else if (cred.valid && cred_ready) begin
            busy <= 2'($urandom_range(3));
            cred_ready <= 1'b0;
        end else begin
            busy <= (busy != 2'h0) ? busy - 2'h1 : 2'h0;
            cred_ready <= (busy == 2'h0);
        end
    end
endmodule // udqs_dma_model
`default_nettype wire

// ===== test/udqs_top_tb.sv
// Self-checking bench of the queue manager, credit scheduler and zero-length path.
`timescale 1ns/1ps
`default_nettype none
module udqs_top_tb;
    import udqs_pkg::*;
    logic clk = 0, rstn = 0, read = 0, write = 0, ret_ready, tx_cmp_irq, rx_cmp_irq;
    logic [9:0] address = '0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = '0, readdata, rd;
    logic waitrequest, cred_ready, sen = 0;
    logic [3:0] chan_en = 4'hB, tx_fifo_full = 4'h1, rx_fifo_empty = 4'h2;
    udqs_ret_s ret = '0;
    udqs_credit_s cred;
    udqs_pkt_s usb_rx = '0, usb_tx;
    udqs_blk_s core_blk, core_tx = '0;
    logic [2:0] tab [6];
    int err_total = 0, checked = 0, p = 0, n, ncred = 0;
    always #25 clk = ~clk;
    udqs_top udqs_top_i (.clk(clk), .rstn(rstn), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .ret(ret), .ret_ready(ret_ready), .tx_cmp_irq(tx_cmp_irq),
        .rx_cmp_irq(rx_cmp_irq), .chan_en(chan_en), .tx_fifo_full(tx_fifo_full),
        .rx_fifo_empty(rx_fifo_empty), .cred_ready(cred_ready), .cred(cred),
        .usb_rx(usb_rx), .core_blk(core_blk), .core_tx(core_tx), .usb_tx(usb_tx));
    udqs_dma_model udqs_dma_model_i (.clk(clk), .rstn(rstn), .cred(cred),
        .cred_ready(cred_ready));
    task automatic give_verdict;
        if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One Avalon access; the request stands until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        if (i == 20) cmp(32'h1, 32'h0);
        if (i == 20) give_verdict();
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // Hands one descriptor to a queue through the return port and checks the event pulses.
    task automatic push(input logic [5:0] q, input logic [31:0] ptr, input logic [1:0] ev);
        int i;
        @(posedge clk);
        ret <= '{1'b1, q, ptr};
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (ret_ready === 1'b1) break;
        end
        if (i == 20) cmp(32'h1, 32'h0);
        if (i == 20) give_verdict();
        ret.valid <= 1'b0;
        #1;
        cmp({30'h0, tx_cmp_irq, rx_cmp_irq}, {30'h0, ev});
    endtask
    function automatic logic elig(input logic [2:0] e);
        return chan_en[e[1:0]] && (e[2] ? !rx_fifo_empty[e[1:0]] : !tx_fifo_full[e[1:0]]);
    endfunction
    // Each accepted credit must be the next eligible table entry in table order.
    always @(posedge clk) begin
        if (sen && cred.valid === 1'b1 && cred_ready === 1'b1) begin
            while (!elig(tab[p])) p = (p == 5) ? 0 : p + 1;
            cmp({29'h0, cred.dir, cred.chan}, {29'h0, tab[p]});
            p = (p == 5) ? 0 : p + 1;
            ncred++;
        end
    end
    // Main sequence.
    initial begin
        n = $urandom(19820);
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        bus(0, 10'h004, 0);
        cmp(rd, 32'h0000_00FF);
        bus(1, 10'h100, 32'h1000);
        bus(1, 10'h104, 32'h0);
        bus(1, 10'h108, 32'h10);
        bus(1, 10'h278, 32'h1000);
        bus(1, 10'h278, 32'h1020);
        bus(0, 10'h378, 0);
        cmp(rd, 2);
        bus(0, 10'h278, 0);
        cmp(rd, 32'h1000);
        bus(1, 10'h27C, 32'h1040);
        bus(1, 10'h000, 32'h801F_001E);
        bus(0, 10'h27C, 0);
        cmp(rd, 32'h1040);
        bus(0, 10'h27C, 0);
        cmp(rd, 32'h1020);
        bus(0, 10'h278, 0);
        cmp(rd, 0);
        push(6'h18, 32'h1080, 2'b10);
        push(6'h1B, 32'h10A0, 2'b01);
        push(6'h28, 32'h10C0, 2'b00);
        bus(0, 10'h2A0, 0);
        cmp(rd, 32'h10C0);
        for (int i = 0; i < 8; i++) begin
            n = (i == 0) ? 0 : $urandom_range(512, 1);
            @(posedge clk);
            usb_rx <= '{1'b1, 16'(n)};
            core_tx <= '{1'b1, 16'(n + 7), {12'h0, i[0], 19'h0}};
            @(posedge clk);
            usb_rx.valid <= 1'b0;
            core_tx.valid <= 1'b0;
            @(posedge clk);
            cmp({core_blk.valid, core_blk.count, 14'h0, core_blk.info2[ZLP_BIT]},
                {1'b1, 16'(n), 14'h0, n == 0});
            cmp({15'h0, usb_tx.valid, usb_tx.len}, {16'h1, i[0] ? 16'h0 : 16'(n + 7)});
        end
        for (int i = 0; i < 6; i++) begin
            tab[i] = (i == 0) ? 3'h3 : 3'($urandom);
            bus(1, 10'h00C, {16'h0, tab[i][2], 5'h0, tab[i][1:0], 8'(i)});
        end
        bus(0, 10'h00C, 0);
        cmp(rd, 0);
        p = 0;
        sen = 1;
        bus(1, 10'h004, 32'h8000_0005);
        for (int i = 0; i < 600 && ncred < 14; i++) @(posedge clk);
        sen = 0;
        cmp(ncred >= 14, 1);
        bus(1, 10'h004, 32'h5);
        bus(0, 10'h008, 0);
        cmp({23'h0, rd[8:0]}, 0);
        give_verdict();
    end
endmodule // udqs_top_tb
`default_nettype wire
